// >>> hw/hust_pins.sv
// Contract
// - Reset serial to 115200 8N1
// - Flow control off until configured
// - Drive RTS to throttle host
// - Sample CTS, hold transmit when unready
// - Store settings only if already active
// - Sleep inhibit low blocks sleep
// - Host pulls attention low: hibernate now
// - Pull attention low on buffer overflow
// - Role select low central, high peripheral
// - Pipe select low pipe, high command
// - Pipe select low overrides disabled profile
// - Data ready low until all sent
// - Link indicator low while linked
// - Pipe select low: link also needs subscription
// - Sleep state low awake, high asleep
// - Factory low at boot enters test mode
// - Factory and pipe low erase settings
// - Test mode persists until factory high
// - Special pin functions individually disableable
// - Floating pipe select: command until active
`timescale 1ns/1ps
`include "hust_regs.svh"
module hust_pins import hust_pkg::*; #(
  parameter int DATA_BITS = `HUST_DATA_BITS,
  parameter int TX_DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Serial pins
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_rts_n,
  input wire logic i_cts_n,
  // Status and control pins
  input wire logic i_sleep_inhibit_in_n,
  input wire logic i_hibernate_attention_io,
  output logic o_hibernate_attention_io,
  output logic o_hibernate_attention_oe_n,
  input wire logic i_role_select_in,
  input wire logic i_pipe_select_in_n,
  input wire logic i_pipe_select_float,
  output logic o_data_ready_out_n,
  output logic o_link_out_n,
  output logic o_sleep_state_out,
  input wire logic i_factory_entry_in_n,
  // Configuration from the command processor
  input wire logic i_set_serial_params_cmd,
  input wire logic [`HUST_DIV_W-1:0] i_cfg_div,
  input wire logic i_cfg_flow_en,
  input wire logic i_store_cmd,
  input wire logic i_set_pin_function_cmd,
  input wire logic [`HUST_FN_W-1:0] i_cfg_pin_fn,
  input wire logic i_pipe_profile_en,
  // Link side
  input wire logic i_link_up,
  input wire logic i_peer_subscribed,
  input wire logic i_pipe_active,
  input wire logic i_sleep_request,
  input wire logic i_host_valid,
  input wire logic [DATA_BITS-1:0] i_host_data,
  input wire logic i_rx_accept,
  // Outputs to the command processor
  output logic o_host_ready,
  output logic o_rx_valid,
  output logic [DATA_BITS-1:0] o_rx_data,
  output logic o_frame_err,
  output logic o_store_ok,
  output logic o_store_refused,
  output logic o_pipe_mode,
  output logic o_central_role,
  output logic o_pipe_start,
  output logic o_hibernate,
  output logic o_factory_mode,
  output logic o_test_mode_entered_event,
  output logic o_erase_settings,
  output logic o_overflow
);
  localparam int PW = $clog2(TX_DEPTH);
  typedef struct packed {
    logic [1:0] rxd_s;
    logic [1:0] cts_s;
    logic [1:0] slp_s;
    logic [1:0] att_s;
    logic [1:0] role_s;
    logic [1:0] pipe_s;
    logic [1:0] flt_s;
    logic [1:0] fac_s;
    hust_mode_t mode;
    logic [`HUST_DIV_W-1:0] div_ram;
    logic flow_ram;
    logic [`HUST_DIV_W-1:0] div_rom;
    logic flow_rom;
    logic [`HUST_FN_W-1:0] pin_fn;
    logic [PW:0] wp;
    logic [PW:0] rp;
    logic rx_pend;
    logic [DATA_BITS-1:0] rx_hold;
    logic float_pipe;
    logic txd;
    logic rts_n;
    logic att_oe_n;
    logic drdy_n;
    logic link_n;
    logic sleep;
    logic host_ready;
    logic store_ok;
    logic store_ref;
    logic pipe_mode;
    logic central;
    logic pipe_start;
    logic test_mode_entered_event_ev;
    logic erase;
    logic ovf;
    logic ferr;
    logic hib;
    logic fmode;
    logic [1:0] boot_cnt;
  } hust_state_t;
  hust_state_t s, next_s;
  logic [DATA_BITS-1:0] fifo [TX_DEPTH];
  logic tx_ready;
  logic tx_txd;
  logic tx_busy;
  logic rx_valid;
  logic [DATA_BITS-1:0] rx_data;
  logic rx_ferr;
  logic fifo_empty;
  logic fifo_full;
  logic fifo_pop;
  logic fifo_push;
  logic cts_hold;
  logic fn_on_att;

  function automatic logic fn_on(input logic [`HUST_FN_W-1:0] f, input int idx);
    fn_on = f[idx];
  endfunction

  assign fifo_empty = (s.wp == s.rp);
  assign fifo_full = (s.wp[PW] != s.rp[PW]) && (s.wp[PW-1:0] == s.rp[PW-1:0]);
  // Hold gates new frames only; a started frame runs to its stop bit
  assign cts_hold = s.flow_ram && s.cts_s[1];
  assign fifo_pop = !fifo_empty && tx_ready && !cts_hold && (s.mode == HUST_RUN);
  assign fifo_push = i_host_valid && !fifo_full && (s.mode == HUST_RUN);
  assign fn_on_att = fn_on(s.pin_fn, `HUST_FN_ATTN);

  hust_uart_tx #(.DATA_BITS(DATA_BITS)) u_tx (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_div(s.div_ram),
    .i_valid(fifo_pop),
    .i_data(fifo[s.rp[PW-1:0]]),
    .i_hold(cts_hold),
    .o_ready(tx_ready),
    .o_txd(tx_txd)
  );

  hust_uart_rx #(.DATA_BITS(DATA_BITS)) u_rx (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_div(s.div_ram),
    .i_rxd(s.rxd_s[1]),
    .o_valid(rx_valid),
    .o_data(rx_data),
    .o_frame_err(rx_ferr)
  );

  // Transmitter busy while its line is not idle or a byte is queued
  assign tx_busy = !tx_ready || !fifo_empty;

  always_comb begin
    next_s = s;
    next_s.rxd_s = {s.rxd_s[0], i_rxd};
    next_s.cts_s = {s.cts_s[0], i_cts_n};
    next_s.slp_s = {s.slp_s[0], i_sleep_inhibit_in_n};
    next_s.att_s = {s.att_s[0], i_hibernate_attention_io};
    next_s.role_s = {s.role_s[0], i_role_select_in};
    next_s.pipe_s = {s.pipe_s[0], i_pipe_select_in_n};
    next_s.flt_s = {s.flt_s[0], i_pipe_select_float};
    next_s.fac_s = {s.fac_s[0], i_factory_entry_in_n};
    next_s.test_mode_entered_event_ev = 1'b0;
    next_s.store_ok = 1'b0;
    next_s.store_ref = 1'b0;
    next_s.pipe_start = 1'b0;
    if (i_set_serial_params_cmd) begin
      next_s.div_ram = i_cfg_div;
      next_s.flow_ram = i_cfg_flow_en;
    end
    // Committing untried settings could lock the host out for good
    if (i_store_cmd) begin
      if (s.div_ram == i_cfg_div && s.flow_ram == i_cfg_flow_en) begin
        next_s.div_rom = s.div_ram;
        next_s.flow_rom = s.flow_ram;
        next_s.store_ok = 1'b1;
      end else begin
        next_s.store_ref = 1'b1;
      end
    end
    if (i_set_pin_function_cmd) begin
      next_s.pin_fn = i_cfg_pin_fn;
    end
    if (fifo_push) begin
      next_s.wp = s.wp + (PW + 1)'(1);
    end
    if (fifo_pop) begin
      next_s.rp = s.rp + (PW + 1)'(1);
    end
    // Receive hold register; overflow when host outruns the reader
    if (rx_valid && s.rx_pend && !i_rx_accept) begin
      next_s.ovf = 1'b1;
    end else if (i_rx_accept && !rx_valid) begin
      next_s.rx_pend = 1'b0;
    end
    if (rx_valid) begin
      next_s.rx_pend = 1'b1;
      next_s.rx_hold = rx_data;
    end
    // Frame errors stay visible until reset, like overflow
    if (rx_ferr) begin
      next_s.ferr = 1'b1;
    end
    unique case (s.mode)
      HUST_BOOT: begin
        // Straps settle through the synchronisers first
        if (s.boot_cnt != `HUST_BOOT_WAIT) begin
          next_s.boot_cnt = s.boot_cnt + 2'h1;
        end else begin
          next_s.mode = HUST_RUN;
          if (!s.fac_s[1] && fn_on(s.pin_fn, `HUST_FN_FACT)) begin
            next_s.mode = HUST_FACTORY;
            next_s.test_mode_entered_event_ev = 1'b1;
            next_s.erase = !s.pipe_s[1];
          end
        end
      end
      HUST_RUN: begin
        if (fn_on_att && !s.att_s[1] && s.att_oe_n) begin
          next_s.mode = HUST_HIBERNATE;
        end
      end
      HUST_FACTORY: begin
        if (s.fac_s[1]) begin
          next_s.mode = HUST_RUN;
        end
      end
      HUST_HIBERNATE: begin
        if (s.att_s[1]) begin
          next_s.mode = HUST_RUN;
        end
      end
    endcase
    // Mode flags come from registers so the pins never glitch on decode
    next_s.hib = (next_s.mode == HUST_HIBERNATE);
    next_s.fmode = (next_s.mode == HUST_FACTORY);
    // Floating select latches pipe mode once the pipe goes live
    if (!s.flt_s[1]) begin
      next_s.float_pipe = 1'b0;
    end else if (i_pipe_active) begin
      next_s.float_pipe = 1'b1;
    end
    next_s.pipe_mode = s.flt_s[1] ? s.float_pipe : !s.pipe_s[1];
    // Floating select starts the pipe only through an enabled profile
    if (s.flt_s[1] && i_pipe_active && !s.float_pipe && i_pipe_profile_en) begin
      next_s.pipe_start = 1'b1;
    end else if (!s.flt_s[1] && !s.pipe_s[1] && !s.pipe_mode) begin
      next_s.pipe_start = 1'b1;
    end
    next_s.central = fn_on(s.pin_fn, `HUST_FN_ROLE) ? !s.role_s[1] : 1'b0;
    next_s.txd = (s.mode == HUST_RUN) ? tx_txd : 1'b1;
    next_s.rts_n = s.flow_ram ? (fifo_full || s.rx_pend) : 1'b0;
    next_s.host_ready = !fifo_full && (s.mode == HUST_RUN);
    // Open-drain: enable low only to pull the line low
    next_s.att_oe_n = !(fn_on_att && s.ovf && s.mode == HUST_RUN);
    if (fn_on(s.pin_fn, `HUST_FN_DRDY)) begin
      next_s.drdy_n = !(s.rx_pend || tx_busy);
    end else begin
      next_s.drdy_n = 1'b1;
    end
    if (!fn_on(s.pin_fn, `HUST_FN_LINK)) begin
      next_s.link_n = 1'b1;
    end else if (s.pipe_mode && !s.pipe_s[1] && !s.flt_s[1]) begin
      next_s.link_n = !(i_link_up && i_peer_subscribed);
    end else begin
      next_s.link_n = !i_link_up;
    end
    // Hibernation reads as asleep; a queued byte keeps the core awake
    if (!fn_on(s.pin_fn, `HUST_FN_SLEEP)) begin
      next_s.sleep = 1'b0;
    end else begin
      next_s.sleep = (s.mode == HUST_HIBERNATE) || (i_sleep_request && s.slp_s[1] && !tx_busy);
    end
  end

  // Storage has no reset; the pointers alone say what is valid
  always_ff @(posedge i_sys_clk) begin
    if (i_ce && fifo_push) begin
      fifo[s.wp[PW-1:0]] <= i_host_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '{rxd_s: 2'h3, cts_s: 2'h3, slp_s: 2'h3, att_s: 2'h3, role_s: 2'h3, pipe_s: 2'h3,
             flt_s: 2'h0, fac_s: 2'h3, mode: HUST_BOOT,
             div_ram: `HUST_DIV_W'(`HUST_BAUD_DIV), flow_ram: 1'b0,
             div_rom: `HUST_DIV_W'(`HUST_BAUD_DIV), flow_rom: 1'b0,
             pin_fn: `HUST_FN_RESET, wp: '0, rp: '0, rx_pend: 1'b0, rx_hold: '0,
             float_pipe: 1'b0, txd: 1'b1, rts_n: 1'b0, att_oe_n: 1'b1, drdy_n: 1'b1,
             link_n: 1'b1, sleep: 1'b0, host_ready: 1'b0, store_ok: 1'b0, store_ref: 1'b0,
             pipe_mode: 1'b0, central: 1'b0, pipe_start: 1'b0, test_mode_entered_event_ev: 1'b0,
             erase: 1'b0, ovf: 1'b0, ferr: 1'b0, hib: 1'b0, fmode: 1'b0,
             boot_cnt: 2'h0};
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_txd = s.txd;
  assign o_rts_n = s.rts_n;
  assign o_hibernate_attention_io = 1'b0;
  assign o_hibernate_attention_oe_n = s.att_oe_n;
  assign o_data_ready_out_n = s.drdy_n;
  assign o_link_out_n = s.link_n;
  assign o_sleep_state_out = s.sleep;
  assign o_host_ready = s.host_ready;
  assign o_rx_valid = s.rx_pend;
  assign o_rx_data = s.rx_hold;
  assign o_frame_err = s.ferr;
  assign o_store_ok = s.store_ok;
  assign o_store_refused = s.store_ref;
  assign o_pipe_mode = s.pipe_mode;
  assign o_central_role = s.central;
  assign o_pipe_start = s.pipe_start;
  assign o_hibernate = s.hib;
  assign o_factory_mode = s.fmode;
  assign o_test_mode_entered_event = s.test_mode_entered_event_ev;
  assign o_erase_settings = s.erase;
  assign o_overflow = s.ovf;
endmodule // hust_pins

// >>> hw/hust_regs.svh
// Constants for the host serial and status pin block
`ifndef HUST_REGS_SVH
`define HUST_REGS_SVH
`define HUST_CLK_HZ 10000000
`define HUST_BAUD_DEFAULT 115200
`define HUST_DATA_BITS 8
`define HUST_BAUD_DIV ((`HUST_CLK_HZ + `HUST_BAUD_DEFAULT / 2) / `HUST_BAUD_DEFAULT)
`define HUST_DIV_W 16
`define HUST_FN_ATTN 0
`define HUST_FN_ROLE 1
`define HUST_FN_DRDY 2
`define HUST_FN_LINK 3
`define HUST_FN_SLEEP 4
`define HUST_FN_FACT 5
`define HUST_FN_W 6
`define HUST_FN_RESET 6'h3F
`define HUST_BOOT_WAIT 2'h2
`endif

// >>> hw/hust_pkg.sv
// Types shared by the host serial and status pin block
package hust_pkg;
  typedef enum logic [1:0] {
    HUST_BOOT = 2'b00,
    HUST_RUN = 2'b01,
    HUST_FACTORY = 2'b10,
    HUST_HIBERNATE = 2'b11
  } hust_mode_t;
  typedef enum logic [1:0] {
    HUST_UIDLE = 2'b00,
    HUST_USTART = 2'b01,
    HUST_UDATA = 2'b10,
    HUST_USTOP = 2'b11
  } hust_ustate_t;
endpackage

// >>> hw/hust_uart_tx.sv
// Serial transmitter, LSB first, one stop bit
`timescale 1ns/1ps
`include "hust_regs.svh"
module hust_uart_tx import hust_pkg::*; #(
  parameter int DATA_BITS = `HUST_DATA_BITS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [`HUST_DIV_W-1:0] i_div,
  input wire logic i_valid,
  input wire logic [DATA_BITS-1:0] i_data,
  input wire logic i_hold,
  output logic o_ready,
  output logic o_txd
);
  typedef struct packed {
    hust_ustate_t st;
    logic [`HUST_DIV_W-1:0] cnt;
    logic [3:0] bitn;
    logic [DATA_BITS-1:0] sh;
    logic txd;
  } hust_tx_t;
  hust_tx_t s, next_s;
  logic tick;
  assign tick = (s.cnt == i_div - `HUST_DIV_W'(1));
  assign o_ready = (s.st == HUST_UIDLE);
  assign o_txd = s.txd;
  always_comb begin
    next_s = s;
    if (s.st != HUST_UIDLE) begin
      next_s.cnt = tick ? '0 : s.cnt + `HUST_DIV_W'(1);
    end
    unique case (s.st)
      HUST_UIDLE: begin
        next_s.txd = 1'b1;
        if (i_valid && !i_hold) begin
          next_s.st = HUST_USTART;
          next_s.sh = i_data;
          next_s.cnt = '0;
          next_s.txd = 1'b0;
        end
      end
      HUST_USTART: begin
        if (tick) begin
          next_s.st = HUST_UDATA;
          next_s.bitn = '0;
          next_s.txd = s.sh[0];
        end
      end
      HUST_UDATA: begin
        if (tick) begin
          if (s.bitn == 4'(DATA_BITS - 1)) begin
            next_s.st = HUST_USTOP;
            next_s.txd = 1'b1;
          end else begin
            next_s.bitn = s.bitn + 4'h1;
            next_s.sh = s.sh >> 1;
            next_s.txd = s.sh[1];
          end
        end
      end
      HUST_USTOP: begin
        if (tick) begin
          next_s.st = HUST_UIDLE;
        end
      end
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '{st: HUST_UIDLE, cnt: '0, bitn: '0, sh: '0, txd: 1'b1};
    end else if (i_ce) begin
      s <= next_s;
    end
  end
endmodule // hust_uart_tx

// >>> hw/hust_uart_rx.sv
// Serial receiver with mid-bit sampling
`timescale 1ns/1ps
`include "hust_regs.svh"
module hust_uart_rx import hust_pkg::*; #(
  parameter int DATA_BITS = `HUST_DATA_BITS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [`HUST_DIV_W-1:0] i_div,
  input wire logic i_rxd,
  output logic o_valid,
  output logic [DATA_BITS-1:0] o_data,
  output logic o_frame_err
);
  typedef struct packed {
    hust_ustate_t st;
    logic [`HUST_DIV_W-1:0] cnt;
    logic [3:0] bitn;
    logic [DATA_BITS-1:0] sh;
    logic valid;
    logic ferr;
  } hust_rx_t;
  hust_rx_t s, next_s;
  logic tick;
  logic half;
  assign tick = (s.cnt == i_div - `HUST_DIV_W'(1));
  assign half = (s.cnt == (i_div >> 1));
  assign o_valid = s.valid;
  assign o_data = s.sh;
  assign o_frame_err = s.ferr;
  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    next_s.ferr = 1'b0;
    next_s.cnt = tick ? '0 : s.cnt + `HUST_DIV_W'(1);
    unique case (s.st)
      HUST_UIDLE: begin
        next_s.cnt = '0;
        if (!i_rxd) begin
          next_s.st = HUST_USTART;
        end
      end
      HUST_USTART: begin
        if (half) begin
          next_s.cnt = '0;
          next_s.bitn = '0;
          next_s.st = i_rxd ? HUST_UIDLE : HUST_UDATA;
        end
      end
      HUST_UDATA: begin
        if (tick) begin
          next_s.sh = {i_rxd, s.sh[DATA_BITS-1:1]};
          if (s.bitn == 4'(DATA_BITS - 1)) begin
            next_s.st = HUST_USTOP;
          end else begin
            next_s.bitn = s.bitn + 4'h1;
          end
        end
      end
      HUST_USTOP: begin
        if (tick) begin
          next_s.st = HUST_UIDLE;
          next_s.valid = i_rxd;
          next_s.ferr = !i_rxd;
        end
      end
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '{st: HUST_UIDLE, cnt: '0, bitn: '0, sh: '0, valid: 1'b0, ferr: 1'b0};
    end else if (i_ce) begin
      s <= next_s;
    end
  end
endmodule // hust_uart_rx

// >>> verification/hust_pins_properties.sv
// Concurrent checks on the host serial and status pins
`timescale 1ns/1ps
`include "hust_regs.svh"
module hust_pins_properties (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_hibernate_attention_io,
  input wire logic i_sleep_inhibit_in_n,
  input wire logic i_link_up,
  input wire logic i_store_cmd,
  input wire logic i_factory_entry_in_n,
  input wire logic o_txd,
  input wire logic o_hibernate_attention_io,
  input wire logic o_hibernate_attention_oe_n,
  input wire logic o_link_out_n,
  input wire logic o_sleep_state_out,
  input wire logic o_store_ok,
  input wire logic o_store_refused,
  input wire logic o_hibernate,
  input wire logic o_factory_mode,
  input wire logic o_test_mode_entered_event,
  input wire logic o_overflow
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic txd_q;
  logic [15:0] run;
  // Length of each low run on the line; every low run lies inside a frame
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      txd_q <= 1'b1;
      run <= 16'h0000;
    end else begin
      txd_q <= o_txd;
      run <= (o_txd != txd_q) ? 16'h0001 : run + 16'h0001;
    end
  end
  property p_bit_time; (o_txd && !txd_q) |-> (run % `HUST_BAUD_DIV == 0); endproperty
  a_bit_time: assert property (p_bit_time) else $error("low run not whole bit times");
  property p_stop; $rose(o_txd) |-> o_txd [*8]; endproperty
  a_stop: assert property (p_stop) else $error("high level too short");
  property p_store; i_store_cmd |-> ##[1:2] (o_store_ok || o_store_refused); endproperty
  a_store: assert property (p_store) else $error("store not answered");
  property p_attn; !o_hibernate_attention_oe_n |-> o_overflow && !o_hibernate_attention_io; endproperty
  a_attn: assert property (p_attn) else $error("attention pulled without overflow");
  property p_hib; (!i_hibernate_attention_io && o_hibernate_attention_oe_n) [*5] |-> o_hibernate; endproperty
  a_hib: assert property (p_hib) else $error("no hibernation");
  property p_inhibit; (!i_sleep_inhibit_in_n) [*5] |-> !o_sleep_state_out || o_hibernate; endproperty
  a_inhibit: assert property (p_inhibit) else $error("asleep while inhibited");
  property p_hib_sleep; o_hibernate [*2] |-> o_sleep_state_out; endproperty
  a_hib_sleep: assert property (p_hib_sleep) else $error("sleep state low in hibernation");
  property p_link; (!i_link_up) [*5] |-> o_link_out_n; endproperty
  a_link: assert property (p_link) else $error("link shown without link");
  property p_event; o_test_mode_entered_event |=> !o_test_mode_entered_event && o_factory_mode; endproperty
  a_event: assert property (p_event) else $error("bad test mode event");
  property p_fact_hold; o_factory_mode && !i_factory_entry_in_n |=> o_factory_mode; endproperty
  a_fact_hold: assert property (p_fact_hold) else $error("test mode left early");
  c_refused: cover property (o_store_refused);
  c_overflow: cover property (o_overflow);
  c_event: cover property (o_test_mode_entered_event);
  c_hib: cover property (o_hibernate);
endmodule // hust_pins_properties
bind hust_pins hust_pins_properties u_props (.*);

// >>> verification/hust_host_model.sv
// Host model: serial sender and receiver with flow control
`timescale 1ns/1ps
`include "hust_regs.svh"
module hust_host_model (
  input wire logic i_sys_clk,
  input wire logic i_txd,
  input wire logic i_rts_n,
  input wire logic i_stall,
  output logic o_rxd,
  output logic o_cts_n
);
  logic [7:0] got[$];
  logic [7:0] b;
  assign o_cts_n = i_stall;
  initial o_rxd = 1'b1;
  task automatic send_byte(input logic [7:0] v, input logic stp = 1'b1);
    while (i_rts_n) begin
      @(posedge i_sys_clk);
      #10;
    end
    for (int i = 0; i < 10; i++) begin
      o_rxd = (i == 0) ? 1'b0 : (i == 9) ? stp : v[i-1];
      repeat (`HUST_BAUD_DIV) @(posedge i_sys_clk);
      #10;
    end
    o_rxd = 1'b1;
  endtask
  // Mid-bit sampling; a frame with a bad stop level is dropped and shows as a miss
  always begin
    @(negedge i_txd);
    repeat (`HUST_BAUD_DIV / 2) @(posedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (`HUST_BAUD_DIV) @(posedge i_sys_clk);
      b[i] = i_txd;
    end
    repeat (`HUST_BAUD_DIV) @(posedge i_sys_clk);
    if (i_txd) got.push_back(b);
  end
endmodule // hust_host_model

// >>> verification/host_uart_and_status_pins_test.sv
// Self-checking bench for the host serial and status pins
`timescale 1ns/1ps
`include "hust_regs.svh"
module host_uart_and_status_pins_test import hust_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, stall = 1'b1, set_cmd = 1'b0, flow = 1'b0, store = 1'b0, pfn_cmd = 1'b0;
  logic sleep_n = 1'b1, hib = 1'b1, role = 1'b1, pipe_n = 1'b1, flt = 1'b0, fact_n = 1'b1, prof = 1'b1;
  logic link = 1'b0, sub = 1'b0, pact = 1'b0, sreq = 1'b0, hv = 1'b0, racc = 1'b0, pm, a, r;
  logic [7:0] hdata = 8'h00, rdata, d;
  logic [5:0] pfn = `HUST_FN_RESET;
  logic rxd, txd, rts_n, cts_n, hio, oe_n, drdy_n, link_n, slp, hready, rvalid, sok, sref;
  logic pmode, crole, pstart, hibo, fmode, tev, erase, ovf, ferr, fp = 1'b0;
  logic [7:0] exp_q[$];
  int compares = 0, n_mismatch = 0, seed = 32'h3D096DB0;
  wire hib_line = hib & (oe_n | hio);
  always #50 clk = ~clk;
  hust_host_model u_host (.i_sys_clk(clk), .i_txd(txd), .i_rts_n(rts_n), .i_stall(stall), .o_rxd(rxd),
    .o_cts_n(cts_n));
  hust_pins dut_u (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_rxd(rxd), .o_txd(txd), .o_rts_n(rts_n),
    .i_cts_n(cts_n), .i_sleep_inhibit_in_n(sleep_n), .i_hibernate_attention_io(hib_line),
    .o_hibernate_attention_io(hio), .o_hibernate_attention_oe_n(oe_n), .i_role_select_in(role),
    .i_pipe_select_in_n(pipe_n), .i_pipe_select_float(flt), .o_data_ready_out_n(drdy_n), .o_link_out_n(link_n),
    .o_sleep_state_out(slp), .i_factory_entry_in_n(fact_n), .i_set_serial_params_cmd(set_cmd),
    .i_cfg_div(`HUST_DIV_W'(`HUST_BAUD_DIV)), .i_cfg_flow_en(flow), .i_store_cmd(store),
    .i_set_pin_function_cmd(pfn_cmd), .i_cfg_pin_fn(pfn), .i_pipe_profile_en(prof), .i_link_up(link),
    .i_peer_subscribed(sub), .i_pipe_active(pact), .i_sleep_request(sreq), .i_host_valid(hv),
    .i_host_data(hdata), .i_rx_accept(racc), .o_host_ready(hready), .o_rx_valid(rvalid), .o_rx_data(rdata),
    .o_frame_err(ferr), .o_store_ok(sok), .o_store_refused(sref), .o_pipe_mode(pmode), .o_central_role(crole),
    .o_pipe_start(pstart), .o_hibernate(hibo), .o_factory_mode(fmode), .o_test_mode_entered_event(tev),
    .o_erase_settings(erase), .o_overflow(ovf));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [7:0] v);
    for (int k = 0; k < 50 && hready !== 1'b1; k++) cyc(1);
    hdata = v;
    hv = 1'b1;
    cyc(1);
    hv = 1'b0;
    exp_q.push_back(v);
    cyc(1);
  endtask
  task automatic do_store(input logic ok);
    store = 1'b1;
    cyc(1);
    store = 1'b0;
    a = 1'b0;
    r = 1'b0;
    repeat (3) begin
      a |= sok;
      r |= sref;
      cyc(1);
    end
    chk_bit(a, ok);
    chk_bit(r, !ok);
  endtask
  task automatic apply_cfg;
    set_cmd = 1'b1;
    cyc(1);
    set_cmd = 1'b0;
    cyc(4);
  endtask
  task automatic drain(input int n);
    for (int k = 0; k < 6000 && u_host.got.size() < n; k++) cyc(1);
    cyc(200);
    chk_byte(8'(u_host.got.size()), 8'(exp_q.size()));
    while (exp_q.size() > 0 && u_host.got.size() > 0) chk_byte(u_host.got.pop_front(), exp_q.pop_front());
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    cyc(60000);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
  initial begin
    cyc(20);
    rst = 1'b0;
    cyc(4);
    chk_bit(txd, 1'b1);
    chk_bit(rts_n, 1'b0);
    chk_bit(drdy_n, 1'b1);
    for (int i = 0; i < 16; i++) begin
      {role, pipe_n, flt, link, sub, pact, sreq, sleep_n, prof} = 9'($random(seed));
      cyc(6);
      fp = flt & (fp | pact);
      pm = flt ? fp : !pipe_n;
      chk_bit(crole, !role);
      chk_bit(pmode, pm);
      chk_bit(link_n, !(link && (flt || pipe_n || sub)));
      chk_bit(slp, sreq && sleep_n);
    end
    {prof, pipe_n, flt, sreq, link} = 5'b01001;
    cyc(6);
    pipe_n = 1'b0;
    a = 1'b0;
    repeat (8) begin
      a |= pstart;
      cyc(1);
    end
    chk_bit(a, 1'b1);
    chk_bit(pmode, 1'b1);
    pipe_n = 1'b1;
    pfn = `HUST_FN_RESET & ~(6'h01 << `HUST_FN_LINK);
    pfn_cmd = 1'b1;
    cyc(1);
    pfn_cmd = 1'b0;
    cyc(6);
    chk_bit(link_n, 1'b1);
    pfn = `HUST_FN_RESET;
    pfn_cmd = 1'b1;
    cyc(1);
    pfn_cmd = 1'b0;
    cyc(6);
    chk_bit(link_n, 1'b0);
    done("pins");
    // Host stalled but flow control still off, so the stall must be ignored
    for (int i = 0; i < 3; i++) push(8'($random(seed)));
    chk_bit(drdy_n, 1'b0);
    drain(3);
    chk_bit(drdy_n, 1'b1);
    do_store(1'b1);
    flow = 1'b1;
    do_store(1'b0);
    apply_cfg;
    do_store(1'b1);
    chk_bit(rts_n, 1'b0);
    push(8'hA5);
    push(8'h3C);
    cyc(2000);
    chk_byte(8'(u_host.got.size()), 8'h00);
    stall = 1'b0;
    drain(2);
    done("transmit");
    flow = 1'b0;
    apply_cfg;
    d = 8'($random(seed));
    u_host.send_byte(d);
    cyc(5);
    chk_bit(rvalid, 1'b1);
    chk_byte(rdata, d);
    chk_bit(ferr, 1'b0);
    chk_bit(drdy_n, 1'b0);
    racc = 1'b1;
    cyc(1);
    racc = 1'b0;
    cyc(4);
    chk_bit(drdy_n, 1'b1);
    u_host.send_byte(8'h5A);
    u_host.send_byte(8'hC3);
    cyc(5);
    chk_bit(ovf, 1'b1);
    chk_bit(oe_n, 1'b0);
    u_host.send_byte(8'h00, 1'b0);
    cyc(5);
    chk_bit(ferr, 1'b1);
    done("receive");
    for (int j = 0; j < 2; j++) begin
      rst = 1'b1;
      fact_n = 1'b0;
      pipe_n = !j[0];
      cyc(3);
      rst = 1'b0;
      a = 1'b0;
      repeat (8) begin
        a |= tev;
        cyc(1);
      end
      chk_bit(a, 1'b1);
      chk_bit(fmode, 1'b1);
      chk_bit(erase, j[0]);
      fact_n = 1'b1;
      cyc(6);
      chk_bit(fmode, 1'b0);
    end
    hib = 1'b0;
    cyc(6);
    chk_bit(hibo, 1'b1);
    chk_bit(slp, 1'b1);
    done("boot and hibernate");
    wrap_up;
  end
endmodule // host_uart_and_status_pins_test
